// file: hw/jids_sequencer.sv
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/100ps
`include "jids_defines.svh"
module jids_sequencer (
	// Bus and clock.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Test port pins.
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic trst_n,
	output logic tdo,
	output logic tdo_oe,
	// Processor side.
	input wire logic reset_pin_n,
	input wire logic fetch_pending,
	output logic core_reset,
	output logic inval_main,
	output logic inval_mini,
	output logic cache_wr,
	output logic cache_wr_mini,
	output logic [26:0] cache_line,
	output logic [2:0] cache_word,
	output logic [31:0] cache_wdata,
	output logic fetch_block
);
	// Synchronisers for pins.
	logic [1:0] tck_s, tms_s, tdi_s, trst_s, rst_s;
	logic tck_d;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tck_s <= 2'h0;
			tms_s <= 2'h0;
			tdi_s <= 2'h0;
			// Active-low pins idle high, so no false reset follows the release of presetn.
			trst_s <= 2'h3;
			rst_s <= 2'h3;
			tck_d <= 1'b0;
		end else begin
			tck_s <= {tck_s[0], tck};
			tms_s <= {tms_s[0], tms};
			tdi_s <= {tdi_s[0], tdi};
			trst_s <= {trst_s[0], trst_n};
			rst_s <= {rst_s[0], reset_pin_n};
			tck_d <= tck_s[1];
		end
	end
	wire tck_rise = tck_s[1] & ~tck_d;
	wire tck_fall = ~tck_s[1] & tck_d;
	wire test_reset = ~trst_s[1];
	wire pin_reset = ~rst_s[1];

	// Test access state machine.
	jids_pkg::jids_tap_t tap, next_tap;
	always_comb begin
		case (tap)
			jids_pkg::JIDS_TLR: next_tap = tms_s[1] ? jids_pkg::JIDS_TLR : jids_pkg::JIDS_RTI;
			jids_pkg::JIDS_RTI: next_tap = tms_s[1] ? jids_pkg::JIDS_SDR : jids_pkg::JIDS_RTI;
			jids_pkg::JIDS_SDR: next_tap = tms_s[1] ? jids_pkg::JIDS_SIR : jids_pkg::JIDS_C1D;
			jids_pkg::JIDS_C1D: next_tap = tms_s[1] ? jids_pkg::JIDS_E1D : jids_pkg::JIDS_SHD;
			jids_pkg::JIDS_SHD: next_tap = tms_s[1] ? jids_pkg::JIDS_E1D : jids_pkg::JIDS_SHD;
			jids_pkg::JIDS_E1D: next_tap = tms_s[1] ? jids_pkg::JIDS_UDR : jids_pkg::JIDS_PD;
			jids_pkg::JIDS_PD: next_tap = tms_s[1] ? jids_pkg::JIDS_E2D : jids_pkg::JIDS_PD;
			jids_pkg::JIDS_E2D: next_tap = tms_s[1] ? jids_pkg::JIDS_UDR : jids_pkg::JIDS_SHD;
			jids_pkg::JIDS_UDR: next_tap = tms_s[1] ? jids_pkg::JIDS_SDR : jids_pkg::JIDS_RTI;
			jids_pkg::JIDS_SIR: next_tap = tms_s[1] ? jids_pkg::JIDS_TLR : jids_pkg::JIDS_C1I;
			jids_pkg::JIDS_C1I: next_tap = tms_s[1] ? jids_pkg::JIDS_E1I : jids_pkg::JIDS_SHI;
			jids_pkg::JIDS_SHI: next_tap = tms_s[1] ? jids_pkg::JIDS_E1I : jids_pkg::JIDS_SHI;
			jids_pkg::JIDS_E1I: next_tap = tms_s[1] ? jids_pkg::JIDS_UIR : jids_pkg::JIDS_PI;
			jids_pkg::JIDS_PI: next_tap = tms_s[1] ? jids_pkg::JIDS_E2I : jids_pkg::JIDS_PI;
			jids_pkg::JIDS_E2I: next_tap = tms_s[1] ? jids_pkg::JIDS_UIR : jids_pkg::JIDS_SHI;
			jids_pkg::JIDS_UIR: next_tap = tms_s[1] ? jids_pkg::JIDS_SDR : jids_pkg::JIDS_RTI;
			default: next_tap = jids_pkg::JIDS_TLR;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tap <= jids_pkg::JIDS_TLR;
		else if (test_reset)
			tap <= jids_pkg::JIDS_TLR;
		else if (tck_rise)
			tap <= next_tap;
	end
	wire upd_dr = tck_rise && tap == jids_pkg::JIDS_UDR;
	wire cap_dr = tck_rise && tap == jids_pkg::JIDS_C1D;

	// Instruction register.
	logic [`JIDS_IR_W-1:0] ir_sh, ir;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ir_sh <= `JIDS_IR_RESET_VAL;
			ir <= `JIDS_IR_RESET_VAL;
		end else if (test_reset || (tck_rise && tap == jids_pkg::JIDS_TLR)) begin
			ir <= `JIDS_IR_RESET_VAL;
		end else if (tck_rise) begin
			if (tap == jids_pkg::JIDS_C1I)
				ir_sh <= 5'h01;
			else if (tap == jids_pkg::JIDS_SHI)
				ir_sh <= {tdi_s[1], ir_sh[`JIDS_IR_W-1:1]};
			else if (tap == jids_pkg::JIDS_UIR)
				ir <= ir_sh;
		end
	end
	wire in_load = ir == `JIDS_IR_CACHE_LOAD;

	// Handshake flags and data shift register.
	logic [`JIDS_DSR_W-1:0] dsr;
	logic halt_mode, hold_reset, tx_ready, rx_ready, xfer_busy;
	logic [31:0] tx_data, rx_data;
	wire wr_en = psel && penable && pwrite;
	wire rd_en = psel && penable && !pwrite;
	wire wr_tx = wr_en && paddr == `JIDS_A_TX;
	wire rd_rx = rd_en && paddr == `JIDS_A_RX;
	wire host_done = upd_dr && ir == `JIDS_IR_HOST_WRITE && dsr[`JIDS_DSR_DONE_BIT];
	wire tx_taken = cap_dr && ir == `JIDS_IR_TX_READ && tx_ready;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			dsr <= '0;
		else if (cap_dr)
			dsr <= (ir == `JIDS_IR_TX_READ) ? {1'b0, tx_data, 2'h0, tx_ready}
				: {33'h0, halt_mode, hold_reset, 1'b0};
		else if (tck_rise && tap == jids_pkg::JIDS_SHD)
			dsr <= {tdi_s[1], dsr[`JIDS_DSR_W-1:1]};
	end
	wire [`JIDS_PKT_W-1:0] pkt = dsr[`JIDS_DSR_W-1 -: `JIDS_PKT_W];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			halt_mode <= 1'b0;
			hold_reset <= 1'b0;
		end else if (test_reset) begin
			halt_mode <= 1'b0;
			hold_reset <= 1'b0;
		end else if (upd_dr && ir == `JIDS_IR_DBG_CTRL_SEL) begin
			hold_reset <= dsr[`JIDS_DSR_HOLD_BIT];
			halt_mode <= dsr[`JIDS_DSR_HALT_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_ready <= 1'b0;
			tx_data <= 32'h0;
		end else if (wr_tx) begin
			tx_ready <= 1'b1;
			tx_data <= pwdata;
		end else if (tx_taken) begin
			tx_ready <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_ready <= 1'b0;
			rx_data <= 32'h0;
		end else if (host_done) begin
			rx_ready <= 1'b1;
			rx_data <= dsr[34:3];
		end else if (rd_rx) begin
			rx_ready <= 1'b0;
		end
	end

	// Busy is raised when the handler signals readiness; the host's done scan clears it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			xfer_busy <= 1'b0;
		else if (host_done)
			xfer_busy <= 1'b0;
		else if (wr_tx)
			xfer_busy <= 1'b1;
	end

	// Packet sequencer for cache functions.
	jids_pkg::jids_ldst_t ld;
	logic [3:0] words_left;
	logic to_mini;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ld <= jids_pkg::JIDS_IDLE;
			words_left <= 4'h0;
			to_mini <= 1'b0;
			cache_line <= 27'h0;
			cache_word <= 3'h0;
			cache_wdata <= 32'h0;
			cache_wr <= 1'b0;
			cache_wr_mini <= 1'b0;
		end else begin
			cache_wr <= 1'b0;
			cache_wr_mini <= 1'b0;
			if (!in_load) begin
				ld <= jids_pkg::JIDS_IDLE;
			end else if (upd_dr) begin
				case (ld)
					jids_pkg::JIDS_IDLE, jids_pkg::JIDS_ADDR: begin
						cache_line <= pkt[32:6];
						cache_word <= 3'h0;
						to_mini <= pkt[2:0] == `JIDS_FN_LOAD_MINI;
						if (pkt[2:0] == `JIDS_FN_LOAD_MAIN || pkt[2:0] == `JIDS_FN_LOAD_MINI) begin
							ld <= jids_pkg::JIDS_DATA;
							words_left <= `JIDS_LINE_WORDS;
						end else begin
							ld <= jids_pkg::JIDS_ADDR;
						end
					end
					jids_pkg::JIDS_DATA: begin
						cache_wdata <= pkt[31:0];
						cache_wr <= ~to_mini;
						cache_wr_mini <= to_mini;
						words_left <= words_left - 4'h1;
						if (words_left == 4'h1)
							ld <= jids_pkg::JIDS_ADDR;
					end
					default: ld <= jids_pkg::JIDS_IDLE;
				endcase
			end else if (cache_wr || cache_wr_mini) begin
				cache_word <= cache_word + 3'h1;
			end
		end
	end

	// Invalidation and internal reset.
	wire inv_line_cmd = in_load && upd_dr && ld != jids_pkg::JIDS_DATA
		&& pkt[2:0] == `JIDS_FN_INV_LINE;
	wire inv_mini_cmd = in_load && upd_dr && ld != jids_pkg::JIDS_DATA
		&& pkt[2:0] == `JIDS_FN_INV_MINI;
	// Load mode shields both caches from a pin reset; a test reset clears it at once.
	wire reset_inval = pin_reset && (test_reset || !in_load);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			inval_main <= 1'b0;
			inval_mini <= 1'b0;
			core_reset <= 1'b1;
		end else begin
			inval_main <= reset_inval || inv_line_cmd;
			inval_mini <= (reset_inval && (test_reset || !halt_mode))
				|| inv_mini_cmd;
			core_reset <= pin_reset || hold_reset;
		end
	end

	// Fetch blocking: fetches are held while a transfer is busy, during a download, and while fetches are pending.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			fetch_block <= 1'b0;
		else
			fetch_block <= xfer_busy || in_load || fetch_pending;
	end

	// Serial output on the falling test clock edge.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tdo <= 1'b0;
			tdo_oe <= 1'b0;
		end else if (tck_fall) begin
			tdo <= (tap == jids_pkg::JIDS_SHI) ? ir_sh[0] : dsr[0];
			tdo_oe <= tap == jids_pkg::JIDS_SHD || tap == jids_pkg::JIDS_SHI;
		end
	end

	// APB slave, zero wait states.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			if (psel && !penable) begin
				case (paddr)
					`JIDS_A_STATUS: prdata <= {28'h0, core_reset, halt_mode, rx_ready, tx_ready};
					`JIDS_A_RX: prdata <= rx_data;
					`JIDS_A_XFER: prdata <= {xfer_busy, 31'h0};
					`JIDS_A_TX: prdata <= tx_data;
					default: begin
						prdata <= 32'h0;
						pslverr <= 1'b1;
					end
				endcase
			end
		end
	end

	hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		hold_reset |=> core_reset) else $error("internal reset dropped while held");
	tx_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_tx |=> tx_ready) else $error("transmit flag not set");
	rx_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		host_done |=> rx_ready && !xfer_busy) else $error("done scan not seen");
	trst_halt_a: assert property (@(posedge pclk) disable iff (!presetn)
		test_reset |=> !halt_mode) else $error("halt mode survives test reset");
	mini_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		pin_reset && halt_mode && !test_reset && !inv_mini_cmd |=> !inval_mini)
		else $error("mini cache invalidated in halt mode");
	inval_a: assert property (@(posedge pclk) disable iff (!presetn)
		pin_reset && !halt_mode && !in_load |=> inval_main && inval_mini)
		else $error("caches kept through reset");
	dual_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
		pin_reset && test_reset |=> inval_main && inval_mini)
		else $error("caches kept through pin and test reset");
	hold_scan_a: assert property (@(posedge pclk) disable iff (!presetn)
		upd_dr && ir == `JIDS_IR_DBG_CTRL_SEL && !test_reset
		|=> hold_reset == $past(dsr[`JIDS_DSR_HOLD_BIT]))
		else $error("reset hold does not follow the scanned bit");
	fetch_a: assert property (@(posedge pclk) disable iff (!presetn)
		in_load |=> fetch_block) else $error("fetches allowed during download");
	drain_a: assert property (@(posedge pclk) disable iff (!presetn)
		fetch_pending |=> fetch_block) else $error("fetches not held while others drain");
	busy_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_tx && !host_done |=> xfer_busy) else $error("busy bit not raised");
	c_load: cover property (@(posedge pclk) cache_wr);
	c_mini: cover property (@(posedge pclk) cache_wr_mini);
	c_done: cover property (@(posedge pclk) host_done);
	c_warm: cover property (@(posedge pclk) pin_reset && halt_mode && !test_reset);
	c_inval: cover property (@(posedge pclk) inv_line_cmd);
endmodule : jids_sequencer

// file: include/jids_defines.svh
`ifndef JIDS_DEFINES_SVH
`define JIDS_DEFINES_SVH
// Instruction register width and codes of the test port.
`define JIDS_IR_W 5
`define JIDS_IR_CACHE_LOAD 5'h07
`define JIDS_IR_DBG_CTRL_SEL 5'h09
`define JIDS_IR_TX_READ 5'h10
`define JIDS_IR_HOST_WRITE 5'h02
`define JIDS_IR_RESET_VAL 5'h1e
// Shift register lengths.
`define JIDS_PKT_W 33
`define JIDS_DSR_W 36
// Cache function codes in bits 2:0 of a packet.
`define JIDS_FN_INV_LINE 3'h0
`define JIDS_FN_INV_MINI 3'h1
`define JIDS_FN_LOAD_MAIN 3'h2
`define JIDS_FN_LOAD_MINI 3'h3
`define JIDS_LINE_WORDS 4'h8
// Bit positions.
`define JIDS_DSR_TX_BIT 0
`define JIDS_DSR_HOLD_BIT 1
`define JIDS_DSR_HALT_BIT 2
`define JIDS_DSR_DONE_BIT 35
`define JIDS_XFER_BUSY_BIT 31
// APB map.
`define JIDS_A_CTRL 12'h000
`define JIDS_A_STATUS 12'h004
`define JIDS_A_TX 12'h008
`define JIDS_A_RX 12'h00c
`define JIDS_A_XFER 12'h010
`define JIDS_A_CMD 12'h014
`define JIDS_A_ADDR 12'h018
`define JIDS_A_DATA 12'h01c
`define JIDS_CTRL_RESET 32'h0000_0000
`endif

// file: include/jids_pkg.sv
package jids_pkg;
	typedef enum logic [2:0] {
		JIDS_IDLE = 3'b000,
		JIDS_ADDR = 3'b001,
		JIDS_DATA = 3'b010
	} jids_ldst_t;
	typedef enum logic [3:0] {
		JIDS_TLR = 4'h0, JIDS_RTI = 4'h1, JIDS_SDR = 4'h2, JIDS_C1D = 4'h3,
		JIDS_SHD = 4'h4, JIDS_E1D = 4'h5, JIDS_PD = 4'h6, JIDS_E2D = 4'h7,
		JIDS_UDR = 4'h8, JIDS_SIR = 4'h9, JIDS_C1I = 4'ha, JIDS_SHI = 4'hb,
		JIDS_E1I = 4'hc, JIDS_PI = 4'hd, JIDS_E2I = 4'he, JIDS_UIR = 4'hf
	} jids_tap_t;
endpackage : jids_pkg

// file: test/jids_host_model.sv
`timescale 1ns/100ps
`include "jids_defines.svh"
module jids_host_model (
	// Test port pins.
	output logic tck,
	output logic tms,
	output logic tdi,
	output logic trst_n,
	input wire logic tdo
);
	// The test clock stands low between scans, as a real probe leaves it.
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
		trst_n = 1'b1;
	end
	// The bench reaches the test reset pin only through here, so the pin keeps one driver.
	task automatic set_trst(input logic v);
		trst_n = v;
	endtask : set_trst
	task automatic tick(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#12;
		tck = 1'b1;
		o = tdo;
		#24;
		tck = 1'b0;
		tdi = ~d;
		#12;
	endtask : tick
	// Counts test clocks in run-test/idle for the settle and drain waits.
	task automatic idle(input int n);
		logic o;
		for (int i = 0; i < n; i++) begin
			tick(1'b0, 1'b0, o);
		end
	endtask : idle
	// Starts and ends in run-test/idle; bit 0 goes first.
	task automatic scan(input logic ir, input int n, input logic [35:0] din,
		output logic [35:0] dout);
		logic o;
		dout = '0;
		tick(1'b1, 1'b0, o);
		if (ir) begin
			tick(1'b1, 1'b0, o);
		end
		tick(1'b0, 1'b0, o);
		tick(1'b0, 1'b0, o);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], o);
			dout[i] = o;
		end
		tick(1'b1, 1'b0, o);
		tick(1'b0, 1'b0, o);
	endtask : scan
	// The download may only start once the handler has raised the flag.
	task automatic poll_tx(input int max, output logic [35:0] q, output logic ok);
		ok = 1'b0;
		scan(1'b1, `JIDS_IR_W, 36'(`JIDS_IR_TX_READ), q);
		for (int k = 0; k < max && !ok; k++) begin
			scan(1'b0, `JIDS_DSR_W, 36'h0, q);
			ok = q[0];
		end
	endtask : poll_tx
endmodule : jids_host_model

// file: test/tb_jids_sequencer.sv
`timescale 1ns/100ps
`include "jids_defines.svh"
module tb_jids_sequencer;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r, txd, rxd, w, last_data, cache_wdata;
	logic cache_wr_mini, tdo_oe;
	logic tck, tms, tdi, trst_n, tdo, reset_pin_n, fetch_pending, core_reset, fetch_block;
	logic inval_main, inval_mini, cache_wr, e, ok, seen_main, seen_mini;
	logic [26:0] cache_line, va, last_line;
	logic [2:0] cache_word, last_word;
	logic [35:0] q;
	int n_mismatch, cmp_count, n_wr, n_mini;
	jids_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo),
		.tdo_oe(tdo_oe), .reset_pin_n(reset_pin_n), .fetch_pending(fetch_pending),
		.core_reset(core_reset), .inval_main(inval_main), .inval_mini(inval_mini),
		.cache_wr(cache_wr), .cache_wr_mini(cache_wr_mini), .cache_line(cache_line),
		.cache_word(cache_word), .cache_wdata(cache_wdata), .fetch_block(fetch_block));
	jids_host_model host (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo));
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (inval_main === 1'b1) seen_main = 1'b1;
		if (inval_mini === 1'b1) seen_mini = 1'b1;
		if (cache_wr_mini === 1'b1) n_mini++;
		if (cache_wr === 1'b1) begin
			n_wr++;
			last_line = cache_line;
			last_word = cache_word;
			last_data = cache_wdata;
		end
	end
	task automatic check(input logic [35:0] got, input logic [35:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic report_and_stop();
		$display("mismatches=%0d comparisons=%0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : report_and_stop
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k == 50) n_mismatch++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic pin_reset(input logic with_trst);
		seen_main = 1'b0;
		seen_mini = 1'b0;
		@(posedge pclk);
		reset_pin_n <= 1'b0;
		host.set_trst(!with_trst);
		repeat (20) @(posedge pclk);
		reset_pin_n <= 1'b1;
		host.set_trst(1'b1);
		repeat (20) @(posedge pclk);
	endtask : pin_reset
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, fetch_pending} = '0;
		{n_mismatch, cmp_count, n_wr, n_mini, seen_main, seen_mini} = '0;
		reset_pin_n = 1'b1;
		r = $urandom(2);
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		host.idle(1);
		apb(1'b0, `JIDS_A_STATUS, 32'h0);
		check({e, r}, 36'h0);
		apb(1'b0, `JIDS_A_CTRL, 32'h0);
		check({e, r}, 36'h1_0000_0000);
		apb(1'b1, 12'hffc, 32'h0);
		check(e, 1'b1);
		// Dynamic download while the handler stub runs.
		txd = $urandom;
		rxd = $urandom;
		va = 27'($urandom);
		fetch_pending <= 1'($urandom);
		apb(1'b1, `JIDS_A_TX, txd);
		apb(1'b0, `JIDS_A_XFER, 32'h0);
		check(r[31], 1'b1);
		apb(1'b0, `JIDS_A_STATUS, 32'h0);
		check(r[0], 1'b1);
		host.poll_tx(4, q, ok);
		check({ok, q[34:3]}, {1'b1, txd});
		host.scan(1'b1, `JIDS_IR_W, 36'(`JIDS_IR_CACHE_LOAD), q);
		check(fetch_block, 1'b1);
		seen_main = 1'b0;
		host.scan(1'b0, 33, {va, 3'h0, `JIDS_FN_INV_LINE}, q);
		host.idle(15);
		check(seen_main, 1'b1);
		check(tdo_oe, 1'b0);
		host.scan(1'b0, 33, {va, 3'h0, `JIDS_FN_LOAD_MAIN}, q);
		for (int i = 0; i < 8; i++) begin
			w = $urandom;
			host.scan(1'b0, 33, {^w, w}, q);
		end
		host.idle(15);
		check(36'(n_wr), 36'h8);
		check(last_line, va);
		check({last_word, last_data}, {3'h7, w});
		// The whole mini cache is dropped first, so the mini line needs no line invalidate.
		seen_mini = 1'b0;
		host.scan(1'b0, 33, {va, 3'h0, `JIDS_FN_INV_MINI}, q);
		host.scan(1'b0, 33, {~va, 3'h0, `JIDS_FN_LOAD_MINI}, q);
		for (int i = 0; i < 8; i++) begin
			w = $urandom;
			host.scan(1'b0, 33, {^w, w}, q);
		end
		host.idle(15);
		check({seen_mini, n_mini[3:0], n_wr[3:0]}, {1'b1, 4'h8, 4'h8});
		host.scan(1'b1, `JIDS_IR_W, 36'(`JIDS_IR_HOST_WRITE), q);
		host.scan(1'b0, 36, {1'b1, rxd, 3'h0}, q);
		apb(1'b0, `JIDS_A_XFER, 32'h0);
		check(r[31], 1'b0);
		apb(1'b0, `JIDS_A_STATUS, 32'h0);
		check(r[1], 1'b1);
		apb(1'b0, `JIDS_A_RX, 32'h0);
		check(r, rxd);
		check(fetch_block, fetch_pending);
		// Warm reset with halt mode and reset-hold set.
		host.scan(1'b1, `JIDS_IR_W, 36'(`JIDS_IR_DBG_CTRL_SEL), q);
		host.scan(1'b0, 36, 36'h6, q);
		pin_reset(1'b0);
		check({seen_main, seen_mini, core_reset}, 3'b101);
		apb(1'b0, `JIDS_A_STATUS, 32'h0);
		check(r[3:2], 2'b11);
		host.idle(2030);
		host.scan(1'b0, 36, 36'h4, q);
		repeat (20) @(posedge pclk);
		check(core_reset, 1'b0);
		host.scan(1'b0, 36, 36'h0, q);
		pin_reset(1'b0);
		check(seen_mini, 1'b1);
		host.scan(1'b0, 36, 36'h4, q);
		pin_reset(1'b1);
		check({seen_main, seen_mini}, 2'b11);
		apb(1'b0, `JIDS_A_STATUS, 32'h0);
		check(r[2], 1'b0);
		report_and_stop();
	end
	initial begin
		#400000;
		n_mismatch++;
		report_and_stop();
	end
endmodule : tb_jids_sequencer
